// >>> sbd_field_decode.sv
// Splits descriptor words 0, 1 and 2 into their fields
`timescale 1ns/1ps
module sbd_field_decode (
	input  wire logic [31:0] w0_i,
	input  wire logic [31:0] w1_i,
	input  wire logic [31:0] w2_i,
	output logic      [6:0]  hub_id_o,
	output logic      [6:0]  port_id_o,
	output logic      [1:0]  speed_o,
	output logic             split_o,
	output logic      [1:0]  kind_o,
	output logic      [1:0]  token_o,
	output logic      [6:0]  func_id_o,
	output logic      [3:0]  endpoint_o,
	output logic      [10:0] mps_o,
	output logic      [14:0] count_o,
	output logic      [15:0] buf_ptr_o,
	output logic      [3:0]  reload_o
);
	assign hub_id_o   = w1_i[sbd_pkg::POS_HUB +: 7];
	assign port_id_o  = w1_i[sbd_pkg::POS_PORT +: 7];
	assign speed_o    = w1_i[sbd_pkg::POS_SPEED +: 2];
	assign split_o    = w1_i[sbd_pkg::POS_SPLIT];
	assign kind_o     = w1_i[sbd_pkg::POS_KIND +: 2];
	assign token_o    = w1_i[sbd_pkg::POS_TOKEN +: 2];
	assign func_id_o  = w1_i[sbd_pkg::POS_FUNC +: 7];
	// Upper three bits in word 1, lowest in word 0
	assign endpoint_o = {w1_i[sbd_pkg::POS_EP_HIGH +: 3],
		w0_i[sbd_pkg::POS_EP_LOW]};
	assign mps_o      = w0_i[sbd_pkg::POS_MPS +: 11];
	assign count_o    = w0_i[sbd_pkg::POS_COUNT +: 15];
	assign buf_ptr_o  = w2_i[sbd_pkg::POS_BUF_PTR +: 16];
	assign reload_o   = w2_i[sbd_pkg::POS_RELOAD +: 4];
endmodule : sbd_field_decode

// >>> sbd_pkg.sv
// Shared constants for the split bulk descriptor decode block
package sbd_pkg;
	// Register byte offsets
	localparam logic [7:0]  OFS_W0        = 8'h00;
	localparam logic [7:0]  OFS_W1        = 8'h04;
	localparam logic [7:0]  OFS_W2        = 8'h08;
	localparam logic [7:0]  OFS_W3        = 8'h0C;
	localparam logic [7:0]  OFS_CPU_ADDR  = 8'h10;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	// Writable bit masks, reserved positions cleared
	localparam logic [31:0] MASK_W0       = 32'h9FFFFFF9;
	localparam logic [31:0] MASK_W1       = 32'hFFFF7FFF;
	localparam logic [31:0] MASK_W2       = 32'h1EFFFF00;
	localparam logic [31:0] MASK_W3       = 32'h00787FFF;
	localparam logic [31:0] RST_WORD      = 32'h00000000;
	// Word 0 fields
	localparam int          POS_ACTIVE    = 0;
	localparam int          POS_COUNT     = 3;
	localparam int          POS_MPS       = 18;
	localparam int          POS_EP_LOW    = 31;
	// Word 1 fields
	localparam int          POS_EP_HIGH   = 0;
	localparam int          POS_FUNC      = 3;
	localparam int          POS_TOKEN     = 10;
	localparam int          POS_KIND      = 12;
	localparam int          POS_SPLIT     = 14;
	localparam int          POS_SPEED     = 16;
	localparam int          POS_PORT      = 18;
	localparam int          POS_HUB       = 25;
	// Word 2 fields
	localparam int          POS_BUF_PTR   = 8;
	localparam int          POS_RELOAD    = 25;
	// Word 3 fields
	localparam int          POS_DONE      = 0;
	localparam int          POS_NAK       = 19;
	// Status register bits
	localparam int          POS_ST_ACTIVE = 0;
	localparam int          POS_ST_NAKEN  = 1;
	localparam int          POS_ST_MPSERR = 2;
	localparam int          POS_ST_TOKERR = 3;
	// Codes
	localparam logic [1:0]  TOK_OUT       = 2'h0;
	localparam logic [1:0]  TOK_IN        = 2'h1;
	localparam logic [1:0]  TOK_SETUP     = 2'h2;
	localparam logic [7:0]  PID_OUT       = 8'hE1;
	localparam logic [7:0]  PID_IN        = 8'h69;
	localparam logic [7:0]  PID_SETUP     = 8'h2D;
	localparam logic [7:0]  PID_NONE      = 8'h00;
	localparam logic [1:0]  SPEED_LOW     = 2'h2;
	localparam logic [1:0]  SPEED_FULL    = 2'h0;
	localparam logic [10:0] FS_MPS_MAX    = 11'h040;
	localparam logic [31:0] CPU_BASE      = 32'h00000400;
	localparam logic [3:0]  RELOAD_OFF    = 4'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;
endpackage : sbd_pkg

// >>> sbd_retry_calc.sv
// Next NAK count, byte tally and retire decision per result
`timescale 1ns/1ps
module sbd_retry_calc (
	input  wire logic        active_i,
	input  wire logic [3:0]  reload_i,
	input  wire logic [3:0]  nak_cnt_i,
	input  wire logic [14:0] done_i,
	input  wire logic [14:0] count_i,
	input  wire logic        res_valid_i,
	input  wire logic        res_ack_i,
	input  wire logic        res_nak_i,
	input  wire logic        res_fatal_i,
	input  wire logic [14:0] res_bytes_i,
	output logic      [3:0]  next_nak_o,
	output logic      [14:0] next_done_o,
	output logic             clear_o
);
	logic [15:0] sum;

	always_comb begin
		sum         = {1'b0, done_i} + {1'b0, res_bytes_i};
		next_nak_o  = nak_cnt_i;
		next_done_o = done_i;
		clear_o     = 1'b0;
		if (active_i && res_valid_i) begin
			if (res_fatal_i) begin
				clear_o = 1'b1;
			end else if (res_nak_i) begin
				// Zero reload: counter left untouched
				if (reload_i != sbd_pkg::RELOAD_OFF) begin
					if (nak_cnt_i != 4'h0) begin
						next_nak_o = nak_cnt_i - 4'h1;
					end
					if (nak_cnt_i <= 4'h1) begin
						clear_o = 1'b1;
					end
				end
			end else if (res_ack_i) begin
				next_nak_o = reload_i;
				next_done_o = sum[15] ? 15'h7FFF : sum[14:0];
				if (sum >= {1'b0, count_i}) begin
					clear_o = 1'b1;
				end
			end
		end
	end
endmodule : sbd_retry_calc

// >>> sbd_split_desc.sv
// Split bulk/control descriptor registers, AXI4-Lite slave and decode
// Functional notes
// - Zero reload value: NAK results leave the retry counter alone.
// - Buffer pointer is internal address: (processor address - 400h) / 8.
// - Hub id in bits 63:57, port id in bits 56:50.
// - Split bit: zero plain high-speed, one split via translator.
// - Token code 00 OUT, 01 IN, 10 SETUP.
// - Seven-bit function address held in the second word.
// - Endpoint index rebuilt from word 1 bits and word 0 top bit.
// - Eleven-bit maximum payload; full-speed limit is 64 bytes.
// - Fifteen-bit byte count bounds the data this descriptor moves.
// - Software sets active bit; hardware clears on completion or fatal error.
// - Speed code S=1,E=0 low-speed, S=0,E=0 full-speed, splits only.
// - Active bit cleared when NAK counter reaches zero with nonzero reload.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module sbd_split_desc (
	input  wire logic        CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic      [1:0]  S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic      [31:0] S_AXI_RDATA_O,
	output logic      [1:0]  S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	input  wire logic        RES_VALID_I,
	input  wire logic        RES_ACK_I,
	input  wire logic        RES_NAK_I,
	input  wire logic        RES_FATAL_I,
	input  wire logic [14:0] RES_BYTES_I,
	output logic             DESC_ACTIVE_O,
	output logic      [6:0]  HUB_ID_O,
	output logic      [6:0]  PORT_ID_O,
	output logic             SPLIT_O,
	output logic             LOW_SPEED_O,
	output logic      [1:0]  EP_KIND_O,
	output logic      [7:0]  TOKEN_PID_O,
	output logic      [6:0]  FUNC_ID_O,
	output logic      [3:0]  ENDPOINT_O,
	output logic      [10:0] MAX_PAYLOAD_O,
	output logic      [14:0] BYTE_COUNT_O,
	output logic      [15:0] BUF_PTR_O,
	output logic             NAK_LIMIT_EN_O,
	output logic             CFG_ERR_O
);
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic [31:0] w0;
	logic [31:0] w1;
	logic [31:0] w2;
	logic [31:0] w3;
	logic        wr_fire;
	logic        wr_w0;
	logic        wr_w1;
	logic        wr_w2;
	logic        wr_w3;
	logic        wr_known;
	logic [31:0] next_rdata;
	logic        rd_known;
	logic [6:0]  hub_id;
	logic [6:0]  port_id;
	logic [1:0]  speed;
	logic        split;
	logic [1:0]  kind;
	logic [1:0]  token;
	logic [6:0]  func_id;
	logic [3:0]  endpoint;
	logic [10:0] mps;
	logic [14:0] count;
	logic [15:0] buf_ptr;
	logic [3:0]  reload;
	logic [3:0]  next_nak;
	logic [14:0] next_done;
	logic        clear_active;
	logic        hw_event;
	logic        mps_err;
	logic        tok_err;
	logic [7:0]  next_pid;
	logic [31:0] cpu_addr;
	logic [31:0] status;

	// Byte-lane merge; masked positions always store zero
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		merge = r & mask;
	endfunction : merge

	// Write channel: address and data taken independently
	assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
	assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
	assign wr_fire = aw_held && w_held && !S_AXI_BVALID_O;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			aw_held <= 1'b1;
			aw_addr <= S_AXI_AWADDR_I;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			w_held <= 1'b1;
			w_data <= S_AXI_WDATA_I;
			w_strb <= S_AXI_WSTRB_I;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		wr_w0 = 1'b0;
		wr_w1 = 1'b0;
		wr_w2 = 1'b0;
		wr_w3 = 1'b0;
		wr_known = 1'b1;
		if ({aw_addr[7:2], 2'h0} == sbd_pkg::OFS_W0) begin
			wr_w0 = wr_fire;
		end else if ({aw_addr[7:2], 2'h0} == sbd_pkg::OFS_W1) begin
			wr_w1 = wr_fire;
		end else if ({aw_addr[7:2], 2'h0} == sbd_pkg::OFS_W2) begin
			wr_w2 = wr_fire;
		end else if ({aw_addr[7:2], 2'h0} == sbd_pkg::OFS_W3) begin
			wr_w3 = wr_fire;
		end else if ({aw_addr[7:2], 2'h0} != sbd_pkg::OFS_CPU_ADDR &&
			{aw_addr[7:2], 2'h0} != sbd_pkg::OFS_STATUS) begin
			wr_known = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= sbd_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			S_AXI_BVALID_O <= 1'b1;
			S_AXI_BRESP_O  <= wr_known ? sbd_pkg::RESP_OKAY
				: sbd_pkg::RESP_DECERR;
		end else if (S_AXI_BREADY_I) begin
			S_AXI_BVALID_O <= 1'b0;
		end
	end

	// Descriptor words
	assign hw_event = RES_VALID_I && w0[sbd_pkg::POS_ACTIVE];

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			w0 <= sbd_pkg::RST_WORD;
		end else if (wr_w0 && w_strb[0]) begin
			// Software value of the active bit wins, so a set is kept
			w0 <= merge(w0, w_data, w_strb, sbd_pkg::MASK_W0);
		end else if (wr_w0) begin
			w0 <= merge(w0, w_data, w_strb, sbd_pkg::MASK_W0);
			if (clear_active) begin
				w0[sbd_pkg::POS_ACTIVE] <= 1'b0;
			end
		end else if (clear_active) begin
			w0[sbd_pkg::POS_ACTIVE] <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			w1 <= sbd_pkg::RST_WORD;
			w2 <= sbd_pkg::RST_WORD;
		end else begin
			if (wr_w1) begin
				w1 <= merge(w1, w_data, w_strb, sbd_pkg::MASK_W1);
			end
			if (wr_w2) begin
				w2 <= merge(w2, w_data, w_strb, sbd_pkg::MASK_W2);
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			w3 <= sbd_pkg::RST_WORD;
		end else if (wr_w3) begin
			w3 <= merge(w3, w_data, w_strb, sbd_pkg::MASK_W3);
		end else if (hw_event) begin
			w3[sbd_pkg::POS_NAK +: 4]   <= next_nak;
			w3[sbd_pkg::POS_DONE +: 15] <= next_done;
		end
	end

	sbd_field_decode u_decode (
		.w0_i       (w0),
		.w1_i       (w1),
		.w2_i       (w2),
		.hub_id_o   (hub_id),
		.port_id_o  (port_id),
		.speed_o    (speed),
		.split_o    (split),
		.kind_o     (kind),
		.token_o    (token),
		.func_id_o  (func_id),
		.endpoint_o (endpoint),
		.mps_o      (mps),
		.count_o    (count),
		.buf_ptr_o  (buf_ptr),
		.reload_o   (reload)
	);

	sbd_retry_calc u_retry (
		.active_i    (w0[sbd_pkg::POS_ACTIVE]),
		.reload_i    (reload),
		.nak_cnt_i   (w3[sbd_pkg::POS_NAK +: 4]),
		.done_i      (w3[sbd_pkg::POS_DONE +: 15]),
		.count_i     (count),
		.res_valid_i (RES_VALID_I),
		.res_ack_i   (RES_ACK_I),
		.res_nak_i   (RES_NAK_I),
		.res_fatal_i (RES_FATAL_I),
		.res_bytes_i (RES_BYTES_I),
		.next_nak_o  (next_nak),
		.next_done_o (next_done),
		.clear_o     (clear_active)
	);

	// Derived checks and token PID
	assign mps_err = split && (speed == sbd_pkg::SPEED_FULL)
		&& (mps > sbd_pkg::FS_MPS_MAX);
	assign tok_err = (token != sbd_pkg::TOK_OUT) &&
		(token != sbd_pkg::TOK_IN) && (token != sbd_pkg::TOK_SETUP);

	always_comb begin
		case (token)
			sbd_pkg::TOK_OUT:   next_pid = sbd_pkg::PID_OUT;
			sbd_pkg::TOK_IN:    next_pid = sbd_pkg::PID_IN;
			sbd_pkg::TOK_SETUP: next_pid = sbd_pkg::PID_SETUP;
			default:            next_pid = sbd_pkg::PID_NONE;
		endcase
	end

	// Processor view of the buffer pointer
	assign cpu_addr = {13'h0000, buf_ptr, 3'h0} + sbd_pkg::CPU_BASE;

	always_comb begin
		status = 32'h00000000;
		status[sbd_pkg::POS_ST_ACTIVE] = w0[sbd_pkg::POS_ACTIVE];
		status[sbd_pkg::POS_ST_NAKEN]  = reload != sbd_pkg::RELOAD_OFF;
		status[sbd_pkg::POS_ST_MPSERR] = mps_err;
		status[sbd_pkg::POS_ST_TOKERR] = tok_err;
	end

	// Registered decoded outputs
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			HUB_ID_O       <= 7'h00;
			PORT_ID_O      <= 7'h00;
			SPLIT_O        <= 1'b0;
			LOW_SPEED_O    <= 1'b0;
			EP_KIND_O      <= 2'h0;
			TOKEN_PID_O    <= sbd_pkg::PID_NONE;
			FUNC_ID_O      <= 7'h00;
			ENDPOINT_O     <= 4'h0;
			MAX_PAYLOAD_O  <= 11'h000;
			BYTE_COUNT_O   <= 15'h0000;
			BUF_PTR_O      <= 16'h0000;
			NAK_LIMIT_EN_O <= 1'b0;
			CFG_ERR_O      <= 1'b0;
		end else begin
			HUB_ID_O       <= hub_id;
			PORT_ID_O      <= port_id;
			SPLIT_O        <= split;
			LOW_SPEED_O    <= split && (speed == sbd_pkg::SPEED_LOW);
			EP_KIND_O      <= kind;
			TOKEN_PID_O    <= next_pid;
			FUNC_ID_O      <= func_id;
			ENDPOINT_O     <= endpoint;
			MAX_PAYLOAD_O  <= mps;
			BYTE_COUNT_O   <= count;
			BUF_PTR_O      <= buf_ptr;
			NAK_LIMIT_EN_O <= reload != sbd_pkg::RELOAD_OFF;
			CFG_ERR_O      <= mps_err || tok_err;
		end
	end

	assign DESC_ACTIVE_O = w0[sbd_pkg::POS_ACTIVE];

	// Read channel
	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

	always_comb begin
		rd_known = 1'b1;
		if ({S_AXI_ARADDR_I[7:2], 2'h0} == sbd_pkg::OFS_W0) begin
			next_rdata = w0;
		end else if ({S_AXI_ARADDR_I[7:2], 2'h0} == sbd_pkg::OFS_W1) begin
			next_rdata = w1;
		end else if ({S_AXI_ARADDR_I[7:2], 2'h0} == sbd_pkg::OFS_W2) begin
			next_rdata = w2;
		end else if ({S_AXI_ARADDR_I[7:2], 2'h0} == sbd_pkg::OFS_W3) begin
			next_rdata = w3;
		end else if ({S_AXI_ARADDR_I[7:2], 2'h0} == sbd_pkg::OFS_CPU_ADDR) begin
			next_rdata = cpu_addr;
		end else if ({S_AXI_ARADDR_I[7:2], 2'h0} == sbd_pkg::OFS_STATUS) begin
			next_rdata = status;
		end else begin
			next_rdata = 32'h00000000;
			rd_known = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O  <= 32'h00000000;
			S_AXI_RRESP_O  <= sbd_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O  <= next_rdata;
			S_AXI_RRESP_O  <= rd_known ? sbd_pkg::RESP_OKAY
				: sbd_pkg::RESP_DECERR;
		end else if (S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end

	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_nak_ignored: assert property (
		(hw_event && RES_NAK_I && !RES_FATAL_I && reload == 4'h0 && !wr_w3
			&& !wr_w0)
		|=> $stable(w3[22:19]) && DESC_ACTIVE_O)
		else $error("NAK changed state with zero reload");

	a_nak_expire: assert property (
		(hw_event && RES_NAK_I && reload != 4'h0 && w3[22:19] == 4'h1
			&& !wr_w0)
		|=> !DESC_ACTIVE_O && w3[22:19] == 4'h0)
		else $error("NAK counter expiry did not retire descriptor");

	a_buf_cpu_addr: assert property (
		S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 8'h10
		|=> S_AXI_RDATA_O == {13'h0000, BUF_PTR_O, 3'h0} + 32'h00000400)
		else $error("Processor buffer address readback wrong");

	a_hub_port: assert property (
		##1 HUB_ID_O == $past(w1[31:25]) && PORT_ID_O == $past(w1[24:18]))
		else $error("Hub or port id not taken from word 1");

	a_split_mode: assert property (
		##1 SPLIT_O == $past(w1[14]))
		else $error("Split select mismatch");

	a_token_pid: assert property (
		$past(w1[11:10]) == 2'h1 |-> TOKEN_PID_O == 8'h69)
		else $error("IN token code gave wrong PID");

	a_func_addr: assert property (
		##1 FUNC_ID_O == $past(w1[9:3]))
		else $error("Function address mismatch");

	a_endpoint_join: assert property (
		##1 ENDPOINT_O == {$past(w1[2:0]), $past(w0[31])})
		else $error("Endpoint index not reassembled");

	a_fs_mps_limit: assert property (
		(w1[14] && w1[17:16] == 2'h0 && w0[28:18] > 11'd64) |=> CFG_ERR_O)
		else $error("Full-speed payload over 64 not flagged");

	a_byte_done: assert property (
		(hw_event && RES_ACK_I && !RES_NAK_I && !RES_FATAL_I && !wr_w0 &&
			{1'b0, w3[14:0]} + {1'b0, RES_BYTES_I} >= {1'b0, w0[17:3]})
		|=> !DESC_ACTIVE_O)
		else $error("Descriptor not retired after full byte count");

	a_active_set: assert property (
		wr_w0 && w_strb[0] && w_data[0] |=> DESC_ACTIVE_O)
		else $error("Software set of active bit lost");

	a_low_speed: assert property (
		LOW_SPEED_O |-> $past(w1[17:16]) == 2'h2 && $past(w1[14]))
		else $error("Low-speed flag without split and code 10");
endmodule : sbd_split_desc

// >>> sbd_tt_model.sv
// Behavioural result source standing in for the host engine and translator
`timescale 1ns/1ps
module sbd_tt_model (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        go_i,
	input  wire logic [1:0]  kind_i,
	input  wire logic [3:0]  delay_i,
	input  wire logic [14:0] bytes_i,
	output logic             busy_o,
	output logic             res_valid_o,
	output logic             res_ack_o,
	output logic             res_nak_o,
	output logic             res_fatal_o,
	output logic      [14:0] res_bytes_o
);
	logic [3:0]  cnt;
	logic [1:0]  kind;
	logic [14:0] bytes;
	logic        tog;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 4'h0;
			kind <= 2'h0;
			bytes <= 15'h0;
			busy_o <= 1'b0;
			res_valid_o <= 1'b0;
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
			res_valid_o <= 1'b0;
			if (go_i) begin
				cnt <= delay_i;
				kind <= kind_i;
				bytes <= bytes_i;
				busy_o <= 1'b1;
			end else if (busy_o && cnt == 4'h0) begin
				res_valid_o <= 1'b1;
				busy_o <= 1'b0;
			end else if (busy_o) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
	// Qualifiers wander outside a result so stale values are never trusted
	assign res_ack_o = res_valid_o ? (kind == 2'h1) : tog;
	assign res_nak_o = res_valid_o ? (kind == 2'h2) : ~tog;
	assign res_fatal_o = res_valid_o ? (kind == 2'h3) : tog;
	assign res_bytes_o = res_valid_o ? bytes : {15{tog}};
endmodule : sbd_tt_model

// >>> test_sbd_split_desc.sv
// Self-checking bench for the split bulk descriptor block
`timescale 1ns/1ps
module test_sbd_split_desc;
	logic clk = 0, rst_b = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic go = 0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0] rk = 2'h0, bresp, rresp, kind, rsp;
	logic [3:0] dly = 4'h0, ep;
	logic [14:0] rb = 15'h0, rbytes, cnt;
	logic awr, wr, bv, arr, rv, rvld, rack, rnak, rfat, busy, act, spl, low;
	logic naken, cfg;
	logic [6:0] hub, port, func;
	logic [7:0] pid;
	logic [10:0] mps;
	logic [15:0] ptr;
	logic [31:0] rdata;
	int n_errors = 0, n_compared = 0, cyc = 0;
	logic [7:0] pids [4] = '{sbd_pkg::PID_OUT, sbd_pkg::PID_IN,
		sbd_pkg::PID_SETUP, sbd_pkg::PID_NONE};
	always #4 clk = ~clk;
	sbd_split_desc dut (.CLK_I(clk), .RST_B_I(rst_b),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .RES_VALID_I(rvld),
		.RES_ACK_I(rack), .RES_NAK_I(rnak), .RES_FATAL_I(rfat),
		.RES_BYTES_I(rbytes), .DESC_ACTIVE_O(act), .HUB_ID_O(hub),
		.PORT_ID_O(port), .SPLIT_O(spl), .LOW_SPEED_O(low), .EP_KIND_O(kind),
		.TOKEN_PID_O(pid), .FUNC_ID_O(func), .ENDPOINT_O(ep),
		.MAX_PAYLOAD_O(mps), .BYTE_COUNT_O(cnt), .BUF_PTR_O(ptr),
		.NAK_LIMIT_EN_O(naken), .CFG_ERR_O(cfg));
	sbd_tt_model tt (.clk_i(clk), .rst_b_i(rst_b), .go_i(go), .kind_i(rk),
		.delay_i(dly), .bytes_i(rb), .busy_o(busy), .res_valid_o(rvld),
		.res_ack_o(rack), .res_nak_o(rnak), .res_fatal_o(rfat),
		.res_bytes_o(rbytes));
	task conclude;
		if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		tb = 0;
		while (!tb) begin
			@(negedge clk);
			ta = awv && awr; tw = wv && wr; tb = bv; rsp = bresp;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
		end
		br <= 0;
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] d);
		logic ta, tr;
		@(posedge clk);
		ara <= a; arv <= 1; rr <= 1;
		tr = 0;
		while (!tr) begin
			@(negedge clk);
			ta = arv && arr; tr = rv; d = rdata; rsp = rresp;
			@(posedge clk);
			if (ta) arv <= 0;
		end
		rr <= 0;
	endtask : axr
	task settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task res(input logic [1:0] k, input logic [14:0] b, input logic [3:0] w);
		@(posedge clk);
		go <= 1; rk <= k; rb <= b; dly <= w;
		@(posedge clk);
		go <= 0;
		do @(negedge clk); while (busy);
		settle;
	endtask : res
	function logic [31:0] mk1(logic [1:0] sp, logic s, logic [1:0] t);
		return {7'h55, 7'h2A, sp, 1'b0, s, 2'h2, t, 7'h3C, 3'h5};
	endfunction : mk1
	function logic [31:0] mk0(logic [10:0] m, logic [14:0] c, logic a);
		return {1'b1, 2'h0, m, c, 2'h0, a};
	endfunction : mk0
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude;
		end
	end
	task t_decode;
		axr(8'h14, rd);
		chk(rd, 32'h0);
		axw(8'h08, {7'h0, 1'b0, 16'h1234, 8'h00});
		axw(8'h04, mk1(2'h2, 1'b1, 2'h0));
		axw(8'h00, mk0(11'h040, 15'h0010, 1'b0));
		settle;
		chk(hub, 7'h55);
		chk(port, 7'h2A);
		chk(spl, 1'b1);
		chk(low, 1'b1);
		chk(kind, 2'h2);
		chk(func, 7'h3C);
		chk(ep, 4'hB);
		chk(mps, 11'h040);
		chk(cnt, 15'h0010);
		chk(ptr, 16'h1234);
		chk(naken, 1'b0);
		axr(8'h10, rd);
		chk(rd, 32'h1234 * 8 + 32'h400);
		for (int t = 0; t < 4; t++) begin
			axw(8'h04, mk1(2'h2, 1'b1, t[1:0]));
			settle;
			chk(pid, pids[t]);
			chk(cfg, t == 3);
		end
		axw(8'h04, mk1(2'h0, 1'b1, 2'h1));
		axw(8'h00, mk0(11'h041, 15'h0010, 1'b0));
		settle;
		chk(low, 1'b0);
		chk(cfg, 1'b1);
		axw(8'h08, 32'hFFFFFFFF);
		axr(8'h08, rd);
		chk(rd, 32'h1EFFFF00);
	endtask : t_decode
	task t_results;
		axw(8'h08, {7'h0, 1'b0, 16'h1234, 8'h00});
		axw(8'h0C, {9'h0, 4'h5, 4'h0, 15'h0});
		axw(8'h00, mk0(11'h040, 15'h0010, 1'b1));
		res(2'h2, 15'h0, 4'h0);
		axr(8'h0C, rd);
		chk(rd, {9'h0, 4'h5, 4'h0, 15'h0});
		chk(act, 1'b1);
		axw(8'h04, mk1(2'h0, 1'b0, 2'h1));
		axw(8'h08, {3'h0, 4'h2, 1'b0, 16'h1234, 8'h00});
		axw(8'h0C, {9'h0, 4'h2, 4'h0, 15'h0});
		res(2'h2, 15'h0, 4'h0);
		chk(act, 1'b1);
		chk(naken, 1'b1);
		chk(spl, 1'b0);
		res(2'h2, 15'h0, 4'h3);
		chk(act, 1'b0);
		axw(8'h0C, 32'h0);
		axw(8'h00, mk0(11'h040, 15'h0010, 1'b1));
		res(2'h1, 15'h000A, 4'h0);
		chk(act, 1'b1);
		res(2'h1, 15'h0006, 4'h5);
		chk(act, 1'b0);
		axr(8'h0C, rd);
		chk(rd, {9'h0, 4'h2, 4'h0, 15'h0010});
		axw(8'h00, mk0(11'h040, 15'h0010, 1'b1));
		res(2'h3, 15'h0, 4'h1);
		chk(act, 1'b0);
	endtask : t_results
	task t_unmapped;
		axw(8'h14, 32'hA5A5A5A5);
		chk(rsp, sbd_pkg::RESP_OKAY);
		axw(8'h20, 32'hA5A5A5A5);
		chk(rsp, sbd_pkg::RESP_DECERR);
		axr(8'h20, rd);
		chk(rsp, sbd_pkg::RESP_DECERR);
		chk(rd, 32'h0);
	endtask : t_unmapped
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		t_decode;
		t_results;
		t_unmapped;
		conclude;
	end
endmodule : test_sbd_split_desc
